// >>> pkg/spc_pkg.sv
// Package for serial channel pin control: types and constants
package spc_pkg;

  // ------------------------------------------------------------
  // Mode encodings
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    SPC_SYNC_ASYNC    = 2'h0,
    SPC_SYNC_EXTERNAL = 2'h1,
    SPC_SYNC_INTERNAL = 2'h2,
    SPC_SYNC_SDLC     = 2'h3
  } spc_sync_mode_t;

  typedef enum logic [1:0] {
    SPC_RCLK_X1  = 2'h0,
    SPC_RCLK_X16 = 2'h1,
    SPC_RCLK_X32 = 2'h2,
    SPC_RCLK_X64 = 2'h3
  } spc_clk_mult_t;

  typedef enum logic [1:0] {
    SPC_P1_RX_CLK  = 2'h0,
    SPC_P1_TX_CLK  = 2'h1,
    SPC_P1_BRG_IN  = 2'h2,
    SPC_P1_PLL_IN  = 2'h3
  } spc_prim_use_t;

  typedef enum logic [2:0] {
    SPC_S2_IN_RX   = 3'h0,
    SPC_S2_IN_TX   = 3'h1,
    SPC_S2_OUT_PLL = 3'h2,
    SPC_S2_OUT_XTL = 3'h3,
    SPC_S2_OUT_BRG = 3'h4,
    SPC_S2_OUT_TX  = 3'h5
  } spc_sec_use_t;

  typedef enum logic [1:0] {
    SPC_DTR_LEVEL = 2'h0,
    SPC_DTR_GPO   = 2'h1,
    SPC_DTR_DMA   = 2'h2
  } spc_dtr_use_t;

  // ------------------------------------------------------------
  // Grouped signals
  // ------------------------------------------------------------
  typedef struct packed {
    logic           req_function;
    spc_sync_mode_t sync_mode;
    logic           xtal_en;
    logic           async_mode;
    logic           auto_enable;
    logic           send_req;
    logic           term_ready;
    spc_dtr_use_t   dtr_use;
    logic           gpo;
    spc_clk_mult_t  rx_mult;
    spc_prim_use_t  prim_use;
    spc_sec_use_t   sec_use;
  } spc_cfg_t;

  typedef struct packed {
    logic rx_clk;
    logic tx_clk;
    logic brg_in;
    logic pll_in;
  } spc_clk_sel_t;

  typedef struct packed {
    logic rise;
    logic fall;
    logic level;
  } spc_edge_t;

  // ------------------------------------------------------------
  // Constants
  // ------------------------------------------------------------
  localparam int unsigned SPC_SYNC_STAGES = 3;
  localparam logic [6:0]  SPC_MULT_1      = 7'h01;
  localparam logic [6:0]  SPC_MULT_16     = 7'h10;
  localparam logic [6:0]  SPC_MULT_32     = 7'h20;
  localparam logic [6:0]  SPC_MULT_64     = 7'h40;
  localparam logic        SPC_RST_REQ_FN  = 1'b0;
  localparam logic [6:0]  SPC_RST_CNT     = 7'h00;

endpackage : spc_pkg

// >>> rtl/spc_in_sync.sv
// Three-stage input synchroniser with edge detection
module spc_in_sync
  import spc_pkg::*;
(
  // Clock and reset
  input  wire logic      clock_i,
  input  wire logic      rst_n_i,
  // Pin and result
  input  wire logic      pin_i,
  output spc_edge_t      edge_o
);

  // ------------------------------------------------------------
  // Stages
  // ------------------------------------------------------------
  logic [SPC_SYNC_STAGES-1:0] stage_q;
  logic                       level_q;
  logic                       agree;

  assign agree = (stage_q[1] == stage_q[2]);

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      stage_q <= '1;
      level_q <= 1'b1;
    end else begin
      stage_q <= {stage_q[1:0], pin_i};
      if (agree) begin
        level_q <= stage_q[2];
      end
    end
  end

  // Each settled change reported once
  assign edge_o.rise  = agree && stage_q[2] && !level_q;
  assign edge_o.fall  = agree && !stage_q[2] && level_q;
  assign edge_o.level = level_q;

endmodule : spc_in_sync

// >>> rtl/spc_clk_route.sv
// Clock source routing for both clock pins
module spc_clk_route
  import spc_pkg::*;
(
  // Selection
  input  spc_prim_use_t   prim_use_i,
  input  spc_sec_use_t    sec_use_i,
  // Sources
  input  wire logic       prim_lvl_i,
  input  wire logic       sec_lvl_i,
  input  wire logic       pll_out_i,
  input  wire logic       xtal_out_i,
  input  wire logic       brg_out_i,
  input  wire logic       tx_clk_int_i,
  // Results
  output spc_clk_sel_t    sel_o,
  output logic            sec_out_o,
  output logic            sec_oe_o
);

  // ------------------------------------------------------------
  // Routing
  // ------------------------------------------------------------
  logic sec_is_out;
  logic sec_drive;

  assign sec_is_out = (sec_use_i != SPC_S2_IN_RX) && (sec_use_i != SPC_S2_IN_TX);
  assign sec_drive  = (sec_use_i == SPC_S2_OUT_PLL) ? pll_out_i  :
                      (sec_use_i == SPC_S2_OUT_XTL) ? xtal_out_i :
                      (sec_use_i == SPC_S2_OUT_BRG) ? brg_out_i  :
                      tx_clk_int_i;

  assign sel_o.rx_clk = (sec_use_i == SPC_S2_IN_RX) ? sec_lvl_i :
                        (prim_use_i == SPC_P1_RX_CLK) ? prim_lvl_i : 1'b0;
  assign sel_o.tx_clk = (sec_use_i == SPC_S2_IN_TX) ? sec_lvl_i :
                        (prim_use_i == SPC_P1_TX_CLK) ? prim_lvl_i : 1'b0;
  assign sel_o.brg_in = (prim_use_i == SPC_P1_BRG_IN) && prim_lvl_i;
  assign sel_o.pll_in = (prim_use_i == SPC_P1_PLL_IN) && prim_lvl_i;
  assign sec_out_o    = sec_is_out && sec_drive;
  assign sec_oe_o     = sec_is_out;

endmodule : spc_clk_route

// >>> rtl/spc_pin_ctrl.sv
// Pin-level control for one serial channel: wait/request, sync, clocks, modem lines
// Behaviour
// RULE1: Wait/request pin open-drain in wait function, driven both levels in request.
// RULE2: Wait function pulls pin low while the addressed target is not ready.
// RULE3: Request function asserts pin when DMA data path is ready.
// RULE4: After reset the wait/request pin uses the wait function.
// RULE5: Async mode, no crystal: sync pin input, only updates sync/hunt flag.
// RULE6: External party drives sync low two receive clocks after sync character.
// RULE7: External sync: assembly starts on receive clock edge before sync assertion.
// RULE8: Internal sync: sync output active only during sync-recognised receive clock cycle.
// RULE9: SDLC mode: sync pin is an output asserted on flag receipt.
// RULE10: Primary clock pin selects receive, transmit, baud input or PLL input.
// RULE11: Async receiver takes receive clock at 1, 16, 32 or 64 times bit rate.
// RULE12: Secondary clock pin inputs rx/tx clock or outputs PLL, crystal, baud, tx.
// RULE13: Terminal-ready output follows its bit, or general output, or DMA request.
// RULE14: Send-request bit set drives the send-request pin low.
// RULE15: Async with auto enable: pin releases high only after transmitter empties.
// RULE16: Otherwise send-request pin follows its bit immediately; usable as output.
// RULE17: Auto enable: clear-to-send low enables transmitter, else general input.
// RULE18: Auto enable: carrier detect enables receiver, else general input.
// RULE19: Both edges on clear-to-send and carrier detect are detected and reported.
// RULE20: Modem and sync inputs synchronised before edge detection, one report each.
module spc_pin_ctrl
  import spc_pkg::*;
(
  // Clock and reset
  input  wire logic       clock_i,
  input  wire logic       rst_n_i,
  // Configuration
  input  spc_cfg_t        cfg_i,
  // Internal status from the channel
  input  wire logic       target_not_ready_i,
  input  wire logic       dma_ready_i,
  input  wire logic       tx_empty_i,
  input  wire logic       sync_found_i,
  input  wire logic       flag_found_i,
  input  wire logic       pll_out_i,
  input  wire logic       xtal_out_i,
  input  wire logic       brg_out_i,
  input  wire logic       tx_clk_int_i,
  // Wait/request pin
  output logic            wait_req_o,
  output logic            wait_req_oe_o,
  // Sync pin
  input  wire logic       sync_pin_i,
  output logic            sync_pin_o,
  output logic            sync_pin_oe_o,
  // Clock pins
  input  wire logic       primary_clock_pin_i,
  input  wire logic       secondary_clock_pin_i,
  output logic            secondary_clock_pin_o,
  output logic            secondary_clock_pin_oe_o,
  // Modem pins
  output logic            term_ready_n_o,
  output logic            send_req_n_o,
  input  wire logic       clear_to_send_n_i,
  input  wire logic       carrier_detect_pin_i,
  // Status to the channel
  output logic            sync_hunt_o,
  output logic            cts_level_o,
  output logic            dcd_level_o,
  output logic            cts_change_o,
  output logic            dcd_change_o,
  output logic            sync_change_o,
  output logic            tx_enable_o,
  output logic            rx_enable_o,
  output logic            rx_clk_o,
  output logic            tx_clk_o,
  output logic            brg_clk_o,
  output logic            pll_clk_o,
  output logic            rx_bit_tick_o,
  output logic            assembly_start_o
);

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic [6:0] mult_of(input spc_clk_mult_t m);
    unique case (m)
      SPC_RCLK_X1:  mult_of = SPC_MULT_1;
      SPC_RCLK_X16: mult_of = SPC_MULT_16;
      SPC_RCLK_X32: mult_of = SPC_MULT_32;
      SPC_RCLK_X64: mult_of = SPC_MULT_64;
    endcase
  endfunction : mult_of

  function automatic logic any_edge(input spc_edge_t e);
    any_edge = e.rise || e.fall;
  endfunction : any_edge

  function automatic logic auto_gate(input logic auto_en, input logic lvl_n);
    auto_gate = !auto_en || !lvl_n;
  endfunction : auto_gate

  // ------------------------------------------------------------
  // Input synchronisers
  // ------------------------------------------------------------
  spc_edge_t cts_e;
  spc_edge_t dcd_e;
  spc_edge_t sync_e;
  spc_edge_t prim_e;
  spc_edge_t sec_e;

  spc_in_sync u_cts (
    .clock_i (clock_i),
    .rst_n_i (rst_n_i),
    .pin_i   (clear_to_send_n_i),
    .edge_o  (cts_e)
  ); // RULE20
  spc_in_sync u_dcd (
    .clock_i (clock_i),
    .rst_n_i (rst_n_i),
    .pin_i   (carrier_detect_pin_i),
    .edge_o  (dcd_e)
  ); // RULE20
  spc_in_sync u_sync (
    .clock_i (clock_i),
    .rst_n_i (rst_n_i),
    .pin_i   (sync_pin_i),
    .edge_o  (sync_e)
  ); // RULE20
  spc_in_sync u_prim (
    .clock_i (clock_i),
    .rst_n_i (rst_n_i),
    .pin_i   (primary_clock_pin_i),
    .edge_o  (prim_e)
  );
  spc_in_sync u_sec (
    .clock_i (clock_i),
    .rst_n_i (rst_n_i),
    .pin_i   (secondary_clock_pin_i),
    .edge_o  (sec_e)
  );

  // ------------------------------------------------------------
  // Clock routing
  // ------------------------------------------------------------
  spc_clk_sel_t clk_sel;
  logic         sec_out;
  logic         sec_oe;

  spc_clk_route u_route (
    .prim_use_i   (cfg_i.prim_use),
    .sec_use_i    (cfg_i.sec_use),
    .prim_lvl_i   (prim_e.level),
    .sec_lvl_i    (sec_e.level),
    .pll_out_i    (pll_out_i),
    .xtal_out_i   (xtal_out_i),
    .brg_out_i    (brg_out_i),
    .tx_clk_int_i (tx_clk_int_i),
    .sel_o        (clk_sel),
    .sec_out_o    (sec_out),
    .sec_oe_o     (sec_oe)
  ); // RULE10 RULE12

  // ------------------------------------------------------------
  // Decode
  // ------------------------------------------------------------
  logic rx_clk_prev_q;
  logic rx_rise;

  logic sync_is_input;
  logic sync_out_mode;
  logic sync_out_d;
  logic wr_d;
  logic wr_oe_d;
  logic auto_async;
  logic send_req_hold_q;
  logic send_req_d;
  logic dtr_d;

  logic [6:0] div_cnt_q;
  logic [6:0] div_cnt_d;
  logic [6:0] div_max;
  logic       rise_pend_q;
  logic       asm_start_d;

  assign rx_rise       = clk_sel.rx_clk && !rx_clk_prev_q;
  assign sync_is_input = !cfg_i.xtal_en &&
                         ((cfg_i.sync_mode == SPC_SYNC_ASYNC) ||
                          (cfg_i.sync_mode == SPC_SYNC_EXTERNAL)); // RULE5
  assign sync_out_mode = !cfg_i.xtal_en &&
                         ((cfg_i.sync_mode == SPC_SYNC_INTERNAL) ||
                          (cfg_i.sync_mode == SPC_SYNC_SDLC));
  // Active low output: low while recognised during the current rx clock cycle
  assign sync_out_d    = (cfg_i.sync_mode == SPC_SYNC_SDLC) ? !flag_found_i  // RULE9
                                                            : !sync_found_i; // RULE8

  // Wait: open-drain, enable only while pulling low; request: always driven
  assign wr_d    = cfg_i.req_function ? !dma_ready_i : 1'b0; // RULE3
  assign wr_oe_d = cfg_i.req_function ? 1'b1 : target_not_ready_i; // RULE1 RULE2

  assign auto_async = cfg_i.async_mode && cfg_i.auto_enable;
  // Clear of the bit waits for the transmitter in auto async mode
  assign send_req_d = cfg_i.send_req ||
                      (auto_async && send_req_hold_q && !tx_empty_i); // RULE14 RULE15 RULE16

  assign dtr_d = (cfg_i.dtr_use == SPC_DTR_GPO) ? !cfg_i.gpo :
                 (cfg_i.dtr_use == SPC_DTR_DMA) ? !dma_ready_i :
                 !cfg_i.term_ready; // RULE13

  assign div_max   = cfg_i.async_mode ? mult_of(cfg_i.rx_mult) : SPC_MULT_1; // RULE11
  assign div_cnt_d = !rx_rise ? div_cnt_q :
                     ((div_cnt_q + 7'h01) >= div_max) ? SPC_RST_CNT :
                     7'(div_cnt_q + 7'h01);

  // Start on the rx rising edge that came just before sync went low
  assign asm_start_d = (cfg_i.sync_mode == SPC_SYNC_EXTERNAL) && sync_is_input &&
                       sync_e.fall && rise_pend_q; // RULE7

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      // Match idle pin level: no false rise
      rx_clk_prev_q   <= 1'b1;
      send_req_hold_q <= 1'b0;
      div_cnt_q       <= SPC_RST_CNT;
      rise_pend_q     <= 1'b0;
    end else begin
      rx_clk_prev_q   <= clk_sel.rx_clk;
      send_req_hold_q <= send_req_d;
      div_cnt_q       <= div_cnt_d;
      if (rx_rise) begin
        rise_pend_q <= 1'b1;
      end else if (sync_e.fall) begin
        rise_pend_q <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // Registered outputs
  // ------------------------------------------------------------
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wait_req_o               <= 1'b0;
      wait_req_oe_o            <= SPC_RST_REQ_FN; // RULE4
      sync_pin_o               <= 1'b1;
      sync_pin_oe_o            <= 1'b0;
      secondary_clock_pin_o    <= 1'b0;
      secondary_clock_pin_oe_o <= 1'b0;

      term_ready_n_o           <= 1'b1;
      send_req_n_o             <= 1'b1;

      sync_hunt_o              <= 1'b0;
      cts_level_o              <= 1'b0;
      dcd_level_o              <= 1'b0;
      cts_change_o             <= 1'b0;
      dcd_change_o             <= 1'b0;
      sync_change_o            <= 1'b0;

      tx_enable_o              <= 1'b0;
      rx_enable_o              <= 1'b0;

      rx_clk_o                 <= 1'b0;
      tx_clk_o                 <= 1'b0;
      brg_clk_o                <= 1'b0;
      pll_clk_o                <= 1'b0;

      rx_bit_tick_o            <= 1'b0;
      assembly_start_o         <= 1'b0;
    end else begin
      // Pin drivers
      wait_req_o               <= wr_d;
      wait_req_oe_o            <= wr_oe_d;
      sync_pin_o               <= sync_out_mode ? sync_out_d : 1'b1;
      sync_pin_oe_o            <= sync_out_mode;
      secondary_clock_pin_o    <= sec_out;
      secondary_clock_pin_oe_o <= sec_oe;

      // Modem outputs
      term_ready_n_o           <= dtr_d;
      send_req_n_o             <= !send_req_d;

      // Status levels and changes
      sync_hunt_o              <= sync_is_input && !sync_e.level; // RULE5
      cts_level_o              <= !cts_e.level;
      dcd_level_o              <= !dcd_e.level;
      cts_change_o             <= any_edge(cts_e); // RULE19
      dcd_change_o             <= any_edge(dcd_e); // RULE19
      sync_change_o            <= sync_is_input && any_edge(sync_e);

      // Enables
      tx_enable_o              <= auto_gate(cfg_i.auto_enable, cts_e.level); // RULE17
      rx_enable_o              <= auto_gate(cfg_i.auto_enable, dcd_e.level); // RULE18

      // Clock levels
      rx_clk_o                 <= clk_sel.rx_clk;
      tx_clk_o                 <= clk_sel.tx_clk;
      brg_clk_o                <= clk_sel.brg_in;
      pll_clk_o                <= clk_sel.pll_in;

      // Pulses
      rx_bit_tick_o            <= rx_rise && (div_cnt_q == SPC_RST_CNT); // RULE11
      assembly_start_o         <= asm_start_d; // RULE7
    end
  end

endmodule : spc_pin_ctrl

// >>> testbench/spc_pin_ctrl_assertions.sv
// Checker for the pin control block ports
module spc_pin_ctrl_assertions
  import spc_pkg::*;
(
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_n_i,
  // Inputs
  input spc_cfg_t  cfg_i,
  input wire logic target_not_ready_i,
  input wire logic dma_ready_i,
  input wire logic tx_empty_i,
  input wire logic sync_found_i,
  input wire logic flag_found_i,
  input wire logic clear_to_send_n_i,
  input wire logic carrier_detect_pin_i,
  // Outputs
  input wire logic wait_req_o,
  input wire logic wait_req_oe_o,
  input wire logic sync_pin_o,
  input wire logic sync_pin_oe_o,
  input wire logic term_ready_n_o,
  input wire logic send_req_n_o,
  input wire logic cts_change_o,
  input wire logic dcd_change_o,
  input wire logic tx_enable_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);

  a_wait_fn_drive: assert property ($past(rst_n_i) && !$past(cfg_i.req_function)
    |-> wait_req_oe_o == $past(target_not_ready_i) && !wait_req_o)
    else $error("wait function pin drive wrong");
  a_req_fn_drive: assert property ($past(rst_n_i) && $past(cfg_i.req_function)
    |-> wait_req_oe_o && wait_req_o != $past(dma_ready_i))
    else $error("request function pin drive wrong");
  a_rts_set: assert property ($past(rst_n_i) && $past(cfg_i.send_req) |-> !send_req_n_o)
    else $error("send request pin not low");
  a_rts_hold: assert property ($past(rst_n_i) && !$past(cfg_i.send_req) &&
    $past(cfg_i.async_mode) && $past(cfg_i.auto_enable) && !$past(tx_empty_i) &&
    !$past(send_req_n_o) |-> !send_req_n_o)
    else $error("send request released before transmitter empty");
  a_rts_follow: assert property ($past(rst_n_i) && !$past(cfg_i.send_req) &&
    (!$past(cfg_i.async_mode) || !$past(cfg_i.auto_enable)) |-> send_req_n_o)
    else $error("send request pin not following bit");
  a_dtr_level: assert property ($past(rst_n_i) && $past(cfg_i.dtr_use) == SPC_DTR_LEVEL
    |-> term_ready_n_o != $past(cfg_i.term_ready))
    else $error("terminal ready pin not following bit");
  a_cts_edge: assert property ($changed(clear_to_send_n_i) |-> ##[2:6] cts_change_o)
    else $error("clear to send edge not reported");
  a_dcd_edge: assert property ($changed(carrier_detect_pin_i) |-> ##[2:6] dcd_change_o)
    else $error("carrier detect edge not reported");
  a_cts_once: assert property (cts_change_o |=> !cts_change_o)
    else $error("clear to send change repeated");
  a_dcd_once: assert property (dcd_change_o |=> !dcd_change_o)
    else $error("carrier detect change repeated");
  a_sync_async_in: assert property ($past(rst_n_i) &&
    $past(cfg_i.sync_mode) == SPC_SYNC_ASYNC |-> !sync_pin_oe_o)
    else $error("sync pin driven in async mode");
  a_sync_found: assert property ($past(rst_n_i) && $past(cfg_i.sync_mode) == SPC_SYNC_INTERNAL
    && !$past(cfg_i.xtal_en) |-> sync_pin_oe_o && sync_pin_o != $past(sync_found_i))
    else $error("internal sync output wrong");
  a_sync_flag: assert property ($past(rst_n_i) && $past(cfg_i.sync_mode) == SPC_SYNC_SDLC &&
    !$past(cfg_i.xtal_en) && $past(flag_found_i) |-> sync_pin_oe_o && !sync_pin_o)
    else $error("flag sync output wrong");
  a_tx_en_off: assert property ($past(rst_n_i) && !$past(cfg_i.auto_enable) |-> tx_enable_o)
    else $error("transmitter not enabled without auto enable");
endmodule : spc_pin_ctrl_assertions

bind spc_pin_ctrl spc_pin_ctrl_assertions spc_pin_ctrl_assertions_inst (.clock_i, .rst_n_i,
  .cfg_i, .target_not_ready_i, .dma_ready_i, .tx_empty_i, .sync_found_i, .flag_found_i,
  .clear_to_send_n_i, .carrier_detect_pin_i, .wait_req_o, .wait_req_oe_o, .sync_pin_o,
  .sync_pin_oe_o, .term_ready_n_o, .send_req_n_o, .cts_change_o, .dcd_change_o, .tx_enable_o);

// >>> testbench/spc_line_model.sv
// Modem and serial line model facing the pin control block
module spc_line_model (
  // Control from the bench
  input  wire logic clock_i,
  input  wire logic cts_on_i,
  input  wire logic dcd_on_i,
  input  wire logic clk_run_i,
  input  wire logic sync_go_i,
  // Device side of the sync pin
  input  wire logic sync_o_i,
  input  wire logic sync_oe_i,
  // Line pins
  output logic      cts_n_o,
  output logic      dcd_n_o,
  output logic      rclk_o,
  output logic      sync_line_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic div_q = 1'b0;
  logic seen_q = 1'b0;
  logic low_q = 1'b0;
  initial begin
    cts_n_o = 1'b1;
    dcd_n_o = 1'b1;
    rclk_o = 1'b1;
  end
  // Receive clock stands still while clk_run_i is low
  always @(negedge clock_i) begin
    cts_n_o <= !cts_on_i;
    dcd_n_o <= !dcd_on_i;
    div_q <= !div_q;
    if (clk_run_i && div_q) begin
      rclk_o <= !rclk_o;
    end
    if (!sync_go_i) begin
      seen_q <= 1'b0;
      low_q <= 1'b0;
    end else if (clk_run_i && div_q && !rclk_o) begin
      seen_q <= 1'b1;
      low_q <= seen_q;
    end
  end
  // Pull-up holds the line high when nobody drives it
  assign sync_line_o = sync_oe_i ? sync_o_i : !low_q;
endmodule : spc_line_model

// >>> testbench/spc_pin_ctrl_test.sv
// Testbench for the serial channel pin control block
module spc_pin_ctrl_test;
  import spc_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock_i = 0, rst_n_i = 0, target_not_ready_i = 0, dma_ready_i = 0, tx_empty_i = 0;
  logic sync_found_i = 0, flag_found_i = 0, pll_out_i = 1, xtal_out_i = 0, brg_out_i = 1;
  logic tx_clk_int_i = 0, cts_on = 0, dcd_on = 0, clk_run = 0, sync_go = 0;
  spc_cfg_t cfg_i = '0;
  logic wait_req_o, wait_req_oe_o, sync_pin_i, sync_pin_o, sync_pin_oe_o, primary_clock_pin_i;
  logic secondary_clock_pin_i, secondary_clock_pin_o, secondary_clock_pin_oe_o, sync_hunt_o;
  logic term_ready_n_o, send_req_n_o, clear_to_send_n_i, carrier_detect_pin_i, cts_level_o;
  logic dcd_level_o, cts_change_o, dcd_change_o, sync_change_o, tx_enable_o, rx_enable_o;
  logic rx_clk_o, tx_clk_o, brg_clk_o, pll_clk_o, rx_bit_tick_o, assembly_start_o, wr_line;
  int err_count = 0, cmp_count = 0, cyc_count = 0, n_cts = 0, n_dcd = 0, n_asm = 0;
  int n_syn = 0, n_rx = 0, n_tk = 0, base, tbase;
  always #25 clock_i = ~clock_i;
  assign secondary_clock_pin_i = secondary_clock_pin_oe_o ? secondary_clock_pin_o : 1'b1;
  assign wr_line = wait_req_oe_o ? wait_req_o : 1'b1;

  spc_pin_ctrl spc_pin_ctrl_inst (.clock_i, .rst_n_i, .cfg_i, .target_not_ready_i,
    .dma_ready_i, .tx_empty_i, .sync_found_i, .flag_found_i, .pll_out_i, .xtal_out_i,
    .brg_out_i, .tx_clk_int_i, .wait_req_o, .wait_req_oe_o, .sync_pin_i, .sync_pin_o,
    .sync_pin_oe_o, .primary_clock_pin_i, .secondary_clock_pin_i, .secondary_clock_pin_o,
    .secondary_clock_pin_oe_o, .term_ready_n_o, .send_req_n_o, .clear_to_send_n_i,
    .carrier_detect_pin_i, .sync_hunt_o, .cts_level_o, .dcd_level_o, .cts_change_o,
    .dcd_change_o, .sync_change_o, .tx_enable_o, .rx_enable_o, .rx_clk_o, .tx_clk_o,
    .brg_clk_o, .pll_clk_o, .rx_bit_tick_o, .assembly_start_o);
  spc_line_model spc_line_model_inst (.clock_i, .cts_on_i(cts_on), .dcd_on_i(dcd_on),
    .clk_run_i(clk_run), .sync_go_i(sync_go), .sync_o_i(sync_pin_o), .sync_oe_i(sync_pin_oe_o),
    .cts_n_o(clear_to_send_n_i), .dcd_n_o(carrier_detect_pin_i), .rclk_o(primary_clock_pin_i),
    .sync_line_o(sync_pin_i));
  // ------------------------------------------------------------
  // Event counters and timeout
  // ------------------------------------------------------------
  always @(posedge clock_i) begin
    cyc_count++;
    if (cts_change_o === 1'b1) n_cts++;
    if (dcd_change_o === 1'b1) n_dcd++;
    if (assembly_start_o === 1'b1) n_asm++;
    if (sync_change_o === 1'b1) n_syn++;
    if ($rose(rx_clk_o)) n_rx++;
    if (rx_bit_tick_o === 1'b1) n_tk++;
    if (cyc_count == 3000) begin
      err_count++;
      wrap_up();
    end
  end
  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(negedge clock_i);
  endtask : cyc
  task automatic chk(input string name, input logic exp, input logic got);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %b seen %b", name, exp, got);
    end
  endtask : chk
  task automatic cnt(input string name, input int exp, input int got);
    cmp_count++;
    if (got != exp) begin
      err_count++;
      $display("MISMATCH %s expected %0d seen %0d", name, exp, got);
    end
  endtask : cnt
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : wrap_up
  // ------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------
  initial begin
    cyc(3);
    rst_n_i = 1;
    chk("wait_oe_rst", 1'b0, wait_req_oe_o);
    target_not_ready_i = 1;
    cyc(1);
    chk("wait_line", 1'b0, wr_line);
    target_not_ready_i = 0;
    cyc(1);
    chk("wait_release", 1'b0, wait_req_oe_o);
    cfg_i.req_function = 1;
    for (int d = 0; d < 2; d++) begin
      dma_ready_i = d[0];
      cyc(1);
      chk("req_line", !d[0], wr_line);
      chk("req_oe", 1'b1, wait_req_oe_o);
    end
    cfg_i.req_function = 0;
    dma_ready_i = 0;
    for (int t = 0; t < 2; t++) begin
      cfg_i.term_ready = t[0];
      cfg_i.gpo = t[0];
      cfg_i.dtr_use = SPC_DTR_LEVEL;
      cyc(1);
      chk("dtr_level", !t[0], term_ready_n_o);
      cfg_i.dtr_use = SPC_DTR_GPO;
      cyc(1);
      chk("dtr_gpo", !t[0], term_ready_n_o);
    end
    $display("test wait_request_terminal done");
    cfg_i.async_mode = 1;
    cfg_i.auto_enable = 1;
    cfg_i.send_req = 1;
    cyc(1);
    chk("rts_set", 1'b0, send_req_n_o);
    cfg_i.send_req = 0;
    cyc(4);
    chk("rts_hold", 1'b0, send_req_n_o);
    tx_empty_i = 1;
    cyc(1);
    chk("rts_empty", 1'b1, send_req_n_o);
    tx_empty_i = 0;
    cfg_i.auto_enable = 0;
    cfg_i.send_req = 1;
    cyc(1);
    cfg_i.send_req = 0;
    cyc(1);
    chk("rts_follow", 1'b1, send_req_n_o);
    $display("test send_request done");
    cfg_i.auto_enable = 1;
    cts_on = 1;
    cyc(10);
    cnt("cts_edges", 1, n_cts);
    chk("tx_en_on", 1'b1, tx_enable_o);
    chk("cts_lvl", 1'b1, cts_level_o);
    dcd_on = 1;
    cyc(10);
    cnt("dcd_edges", 1, n_dcd);
    chk("rx_en_on", 1'b1, rx_enable_o);
    cts_on = 0;
    dcd_on = 0;
    cyc(10);
    cnt("cts_edges2", 2, n_cts);
    cnt("dcd_edges2", 2, n_dcd);
    chk("tx_en_off", 1'b0, tx_enable_o);
    chk("rx_en_off", 1'b0, rx_enable_o);
    cfg_i.auto_enable = 0;
    cyc(2);
    chk("rx_en_gp", 1'b1, rx_enable_o);
    $display("test modem_inputs done");
    cfg_i.sec_use = SPC_S2_OUT_TX;
    base = n_rx;
    tbase = n_tk;
    clk_run = 1;
    sync_go = 1;
    cyc(20);
    chk("sync_hunt", 1'b1, sync_hunt_o);
    chk("sync_in_oe", 1'b0, sync_pin_oe_o);
    cnt("sync_edges", 1, n_syn);
    chk("rx_clk_runs", 1'b1, n_rx > base);
    cnt("bit_ticks", n_rx - base, n_tk - tbase);
    sync_go = 0;
    cyc(10);
    cfg_i.sync_mode = SPC_SYNC_EXTERNAL;
    sync_go = 1;
    cyc(20);
    cnt("asm_start", 1, n_asm);
    sync_go = 0;
    cfg_i.prim_use = SPC_P1_TX_CLK;
    cfg_i.sec_use = SPC_S2_IN_TX;
    cyc(6);
    base = n_rx;
    cyc(20);
    cnt("rx_clk_moved", base, n_rx);
    clk_run = 0;
    for (int m = 2; m < 4; m++) begin
      cfg_i.sync_mode = spc_sync_mode_t'(m);
      sync_found_i = (m == 2);
      flag_found_i = (m == 3);
      cyc(1);
      chk("sync_out_act", 1'b0, sync_pin_o);
      chk("sync_out_oe", 1'b1, sync_pin_oe_o);
      sync_found_i = 0;
      flag_found_i = 0;
      cyc(1);
      if (m == 2) chk("sync_out_idle", 1'b1, sync_pin_o);
    end
    for (int s = 0; s < 6; s++) begin
      cfg_i.sec_use = spc_sec_use_t'(s);
      cyc(2);
      chk("sec_oe", 1'(s > 1), secondary_clock_pin_oe_o);
    end
    $display("test sync_and_clocks done");
    wrap_up();
  end
endmodule : spc_pin_ctrl_test
